// >>> rtl/dacs_pkg.sv
// Constants, encodings and state type for the DAC serial target.
// Assumes one 50 MHz system clock shared by every user of this package.
package dacs_pkg;
  // Register pointers and reset values
  localparam logic [7:0]  PTR_MODE        = 8'h00;
  localparam logic [7:0]  PTR_CODE        = 8'h01;
  localparam logic [1:0]  PD_RESET        = 2'h0;
  localparam logic [15:0] CODE_RESET      = 16'h0000;
  localparam logic [7:0]  HOLD_RESET      = 8'h00;
  localparam int          PD_LSB          = 0;
  localparam int          PD_MSB          = 1;
  // Power-down selections
  localparam logic [1:0]  PD_NORMAL       = 2'h0;
  localparam logic [1:0]  PD_1K_GND       = 2'h1;
  localparam logic [1:0]  PD_100K_GND     = 2'h2;
  localparam logic [1:0]  PD_HIGH_Z       = 2'h3;
  // Address-select strap encodings and resulting target addresses
  localparam logic [1:0]  STRAP_GND       = 2'h0;
  localparam logic [1:0]  STRAP_VCC       = 2'h1;
  localparam logic [1:0]  STRAP_SDA       = 2'h2;
  localparam logic [1:0]  STRAP_SCL       = 2'h3;
  localparam logic [6:0]  ADDR_GND        = 7'h0D;
  localparam logic [6:0]  ADDR_VCC        = 7'h0E;
  localparam logic [6:0]  ADDR_SDA        = 7'h0C;
  localparam logic [6:0]  ADDR_SCL        = 7'h0F;
  localparam logic [6:0]  ADDR_FIXED      = 7'h0C;
  // Counts in bits, bytes and clock cycles
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT     = 4'h7;
  localparam logic [1:0]  STRAP_SETTLE    = 2'h3;
  localparam logic [1:0]  LAST_BYTE_IDX   = 2'h2;
  // Transfer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } dacs_state_e;
endpackage

// >>> rtl/dacs_line_if.sv
// Bus events decoded from the serial pins, passed from the pin front end to the core.
// Assumes all members are produced on the system clock.
interface dacs_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport phy  (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport core (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// >>> rtl/dacs_pin_sync.sv
// Pin front end: synchronises SCL and SDA and decodes edges, start and stop.
// Assumes raw asynchronous pin levels that idle high.
module dacs_pin_sync (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  dacs_line_if.phy  line
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;

  // Two stages per pin; only the second stage and its delayed copy feed decode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
      prev_r <= 2'h3;
    end else begin
      meta_r <= {scl_in, sda_in};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // SDA moving while SCL stays high frames a transfer
  assign line.scl_rise = sync_r[1] & ~prev_r[1];
  assign line.scl_fall = ~sync_r[1] & prev_r[1];
  assign line.start    = sync_r[1] & prev_r[1] & prev_r[0] & ~sync_r[0];
  assign line.stop     = sync_r[1] & prev_r[1] & ~prev_r[0] & sync_r[0];
  assign line.sda      = sync_r[0];
endmodule

// >>> rtl/dacs_top.sv
// Serial target and register logic of a single-channel 16-bit voltage DAC.
// Assumes an external controller owns SCL; SDA is open drain, pulled up outside.
// What this block does
// - Code register is unsigned straight binary, 0 to 65535, driving the converter.
// - After reset the converter code is zero, so the output sits at 0 V.
// - Target address from strap: GND 0001101, VCC 0001110, SDA 0001100, SCL 0001111.
// - Variant without strap pin answers only to address 0001100.
// - Mode register at pointer 0x00, eight bits, resets to 0x00.
// - Code register at pointer 0x01, sixteen bits read/write, resets to 0x0000.
// - Mode bits 7..2 read zero and ignore writes; bits 1..0 are power-down select.
// - Power-down 00 normal, 01 1k to ground, 10 100k to ground, 11 high-Z.
// - First write byte after address is the pointer and is latched.
// - Following write bytes go to the pointed register: one mode, two code.
// - Code bytes travel high byte first, then low byte, both directions.
// - Read is pointer write, repeated address with read bit, then the pointed register's bytes.
// - Code register reads return high byte, then low byte.
// - A not-acknowledge from the controller ends the read; SDA is released.
module dacs_top #(
  parameter int unsigned HAS_ADDR_PIN = 1
) (
  input  wire logic        CLOCK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  input  wire logic [1:0]  ADDR_STRAP_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT,
  output logic [15:0]      DAC_CODE_OUT,
  output logic [1:0]       POWER_DOWN_SELECT_OUT
);
  if (HAS_ADDR_PIN > 1) begin : g_bad_param
    $error("HAS_ADDR_PIN must be 0 or 1");
  end

  dacs_line_if line ();
  dacs_pkg::dacs_state_e state_r;
  logic [3:0]  bit_cnt_r;
  logic [1:0]  byte_idx_r;
  logic [1:0]  idx_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic        rw_r;
  logic        nack_r;
  logic        sda_oe_r;
  logic        sda_out_r;
  logic [1:0]  power_down_select_r;
  logic [15:0] code_r;
  logic [7:0]  hold_hi_r;
  logic [1:0]  strap_meta_r;
  logic [1:0]  strap_sync_r;
  logic [1:0]  settle_r;
  logic [6:0]  own_addr_r;
  logic        rx_state;
  logic        rx_done;
  logic        addr_hit;
  logic        wr_byte;
  logic        mode_wr;
  logic        hi_wr;
  logic        code_commit;
  logic [7:0]  rd_first;
  logic [7:0]  rd_next;

  dacs_pin_sync u_pins (
    .clk_in   (CLOCK_IN),
    .rst_n_in (RESETN_IN),
    .scl_in   (SCL_IN),
    .sda_in   (SDA_IN),
    .line     (line.phy)
  );

  // Byte returned for a pointer and byte position
  function automatic logic [7:0] read_byte(input logic [7:0] ptr, input logic [1:0] idx,
                                           input logic [1:0] pd, input logic [15:0] code);
    logic [7:0] b;
    b = 8'h00;
    if (ptr == dacs_pkg::PTR_MODE && idx == 2'h0) begin
      b = {6'h00, pd};
    end else if (ptr == dacs_pkg::PTR_CODE && idx == 2'h0) begin
      b = code[15:8];
    end else if (ptr == dacs_pkg::PTR_CODE && idx == 2'h1) begin
      b = code[7:0];
    end
    return b;
  endfunction

  // Address from strap value
  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    logic [6:0] a;
    a = dacs_pkg::ADDR_GND;
    case (s)
      dacs_pkg::STRAP_VCC: a = dacs_pkg::ADDR_VCC;
      dacs_pkg::STRAP_SDA: a = dacs_pkg::ADDR_SDA;
      dacs_pkg::STRAP_SCL: a = dacs_pkg::ADDR_SCL;
      default:             a = dacs_pkg::ADDR_GND;
    endcase
    return a;
  endfunction

  // Strap is caught a few cycles after reset release, once the synchroniser holds it
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      strap_meta_r <= 2'h0;
      strap_sync_r <= 2'h0;
      settle_r     <= 2'h0;
      own_addr_r   <= dacs_pkg::ADDR_FIXED;
    end else begin
      strap_meta_r <= ADDR_STRAP_IN;
      strap_sync_r <= strap_meta_r;
      if (settle_r != dacs_pkg::STRAP_SETTLE) begin
        settle_r <= settle_r + 2'h1;
      end
      if (settle_r == dacs_pkg::STRAP_SETTLE - 2'h1) begin
        own_addr_r <= (HAS_ADDR_PIN != 0) ? strap_addr(strap_sync_r) : dacs_pkg::ADDR_FIXED;
      end
    end
  end

  // Decoded transfer events
  assign rx_state    = (state_r == dacs_pkg::ST_ADDR) || (state_r == dacs_pkg::ST_PTR) ||
                       (state_r == dacs_pkg::ST_WDATA);
  assign rx_done     = line.scl_fall && rx_state && (bit_cnt_r == dacs_pkg::BITS_PER_BYTE);
  assign addr_hit    = (shift_r[7:1] == own_addr_r);
  assign wr_byte     = rx_done && (state_r == dacs_pkg::ST_WDATA);
  assign mode_wr     = wr_byte && (ptr_r == dacs_pkg::PTR_MODE) && (byte_idx_r == 2'h0);
  assign hi_wr       = wr_byte && (ptr_r == dacs_pkg::PTR_CODE) && (byte_idx_r == 2'h0);
  assign code_commit = wr_byte && (ptr_r == dacs_pkg::PTR_CODE) && (byte_idx_r == 2'h1);
  assign idx_nxt     = (byte_idx_r == dacs_pkg::LAST_BYTE_IDX) ? byte_idx_r : byte_idx_r + 2'h1;
  assign rd_first    = read_byte(ptr_r, 2'h0, power_down_select_r, code_r);
  assign rd_next     = read_byte(ptr_r, idx_nxt, power_down_select_r, code_r);

  // Receive shifter, MSB first on SCL rise
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      shift_r <= 8'h00;
    end else if (line.scl_rise && rx_state && bit_cnt_r != dacs_pkg::BITS_PER_BYTE) begin
      shift_r <= {shift_r[6:0], line.sda};
    end
  end

  // Transfer sequencer; start restarts from any state, stop always idles
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_r    <= dacs_pkg::ST_IDLE;
      bit_cnt_r  <= 4'h0;
      byte_idx_r <= 2'h0;
      ptr_r      <= dacs_pkg::PTR_MODE;
      rw_r       <= 1'h0;
      nack_r     <= 1'h0;
    end else if (line.start) begin
      state_r   <= dacs_pkg::ST_ADDR;
      bit_cnt_r <= 4'h0;
    end else if (line.stop) begin
      state_r <= dacs_pkg::ST_IDLE;
    end else begin
      if (line.scl_rise && rx_state && bit_cnt_r != dacs_pkg::BITS_PER_BYTE) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      case (state_r)
        dacs_pkg::ST_IDLE: begin
        end
        dacs_pkg::ST_ADDR: begin
          if (rx_done) begin
            rw_r    <= shift_r[0];
            state_r <= addr_hit ? dacs_pkg::ST_ADDR_ACK : dacs_pkg::ST_IDLE;
          end
        end
        dacs_pkg::ST_ADDR_ACK: begin
          if (line.scl_fall) begin
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= 2'h0;
            state_r    <= rw_r ? dacs_pkg::ST_RDATA : dacs_pkg::ST_PTR;
          end
        end
        dacs_pkg::ST_PTR: begin
          if (rx_done) begin
            ptr_r   <= shift_r;
            state_r <= dacs_pkg::ST_PTR_ACK;
          end
        end
        dacs_pkg::ST_PTR_ACK: begin
          if (line.scl_fall) begin
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= 2'h0;
            state_r    <= dacs_pkg::ST_WDATA;
          end
        end
        dacs_pkg::ST_WDATA: begin
          if (rx_done) begin
            state_r <= dacs_pkg::ST_WDATA_ACK;
          end
        end
        dacs_pkg::ST_WDATA_ACK: begin
          if (line.scl_fall) begin
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= idx_nxt;
            state_r    <= dacs_pkg::ST_WDATA;
          end
        end
        dacs_pkg::ST_RDATA: begin
          if (line.scl_fall) begin
            if (bit_cnt_r == dacs_pkg::LAST_TX_BIT) begin
              state_r <= dacs_pkg::ST_RDATA_ACK;
            end else begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        dacs_pkg::ST_RDATA_ACK: begin
          if (line.scl_rise) begin
            nack_r <= line.sda;
          end
          if (line.scl_fall) begin
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= idx_nxt;
            state_r    <= nack_r ? dacs_pkg::ST_IDLE : dacs_pkg::ST_RDATA;
          end
        end
        default: begin
          state_r <= dacs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // SDA driver: changes just after SCL falls, or releases on start or stop, so data holds while SCL is high
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sda_oe_r  <= 1'h0;
      sda_out_r <= 1'h0;
      tx_r      <= 8'h00;
    end else begin
      sda_out_r <= 1'h0;              // Open drain: only ever pulls low
      if (line.start || line.stop) begin
        sda_oe_r <= 1'h0;
      end else if (rx_done) begin
        sda_oe_r <= (state_r != dacs_pkg::ST_ADDR) || addr_hit;
      end else if (line.scl_fall) begin
        case (state_r)
          dacs_pkg::ST_ADDR_ACK: begin
            tx_r     <= rd_first;
            sda_oe_r <= rw_r & ~rd_first[7];
          end
          dacs_pkg::ST_PTR_ACK,
          dacs_pkg::ST_WDATA_ACK: begin
            sda_oe_r <= 1'h0;
          end
          dacs_pkg::ST_RDATA: begin
            tx_r     <= {tx_r[6:0], 1'b0};
            sda_oe_r <= (bit_cnt_r != dacs_pkg::LAST_TX_BIT) & ~tx_r[6];
          end
          dacs_pkg::ST_RDATA_ACK: begin
            tx_r     <= rd_next;
            sda_oe_r <= ~nack_r & ~rd_next[7];
          end
          default: begin
            sda_oe_r <= sda_oe_r;
          end
        endcase
      end
    end
  end

  // Register file; reset leaves the converter at zero code and normal mode
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      power_down_select_r <= dacs_pkg::PD_RESET;
      code_r              <= dacs_pkg::CODE_RESET;
      hold_hi_r           <= dacs_pkg::HOLD_RESET;
    end else begin
      if (mode_wr) begin
        power_down_select_r <= shift_r[dacs_pkg::PD_MSB:dacs_pkg::PD_LSB];
      end
      if (hi_wr) begin
        hold_hi_r <= shift_r;
      end
      if (code_commit) begin
        code_r <= {hold_hi_r, shift_r};
      end
    end
  end

  assign SDA_OUT               = sda_out_r;
  assign SDA_OE_OUT            = sda_oe_r;
  assign DAC_CODE_OUT          = code_r;
  assign POWER_DOWN_SELECT_OUT = power_down_select_r;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_code_changes_commit: assert property (!$stable(code_r) |-> $past(code_commit))
    else $error("code changed without a full two-byte write");
  a_code_word_order: assert property (code_commit |=> code_r == {$past(hold_hi_r), $past(shift_r)})
    else $error("code word not assembled high byte first");
  a_half_code_hold: assert property (hi_wr |=> $stable(code_r) && hold_hi_r == $past(shift_r))
    else $error("high byte touched the converter code");
  a_mode_low_bits: assert property (mode_wr |=> power_down_select_r == $past(shift_r[1:0]))
    else $error("power-down select not written from low bits");
  // Only the first byte of a mode read carries the register; code bytes are checked apart
  a_mode_read_zero: assert property ($rose(state_r == dacs_pkg::ST_RDATA) && ptr_r == dacs_pkg::PTR_MODE
                                     && byte_idx_r == 2'h0
                                     |-> tx_r[7:2] == 6'h00 && tx_r[1:0] == power_down_select_r)
    else $error("mode read byte has nonzero upper bits");
  a_code_read_high: assert property ($rose(state_r == dacs_pkg::ST_RDATA) && ptr_r == dacs_pkg::PTR_CODE
                                     && byte_idx_r == 2'h0 |-> tx_r == code_r[15:8])
    else $error("code read did not start with high byte");
  a_code_read_low: assert property ($rose(state_r == dacs_pkg::ST_RDATA) && ptr_r == dacs_pkg::PTR_CODE
                                    && byte_idx_r == 2'h1 |-> tx_r == code_r[7:0])
    else $error("code read did not follow with low byte");
  a_unknown_ptr_quiet: assert property (wr_byte && ptr_r > dacs_pkg::PTR_CODE
                                        |=> $stable(code_r) && $stable(power_down_select_r))
    else $error("write through unknown pointer changed a register");
  a_foreign_addr_silent: assert property (rx_done && state_r == dacs_pkg::ST_ADDR && !addr_hit
                                          |=> !sda_oe_r [*4])
    else $error("target drove SDA for a foreign address");
  a_own_addr_ack: assert property (rx_done && state_r == dacs_pkg::ST_ADDR && addr_hit
                                   |=> sda_oe_r && state_r == dacs_pkg::ST_ADDR_ACK)
    else $error("matching address not acknowledged");
  a_pointer_latched: assert property (rx_done && state_r == dacs_pkg::ST_PTR |=> ptr_r == $past(shift_r))
    else $error("pointer byte not latched");
  a_nack_release: assert property (line.scl_fall && state_r == dacs_pkg::ST_RDATA_ACK && nack_r
                                   |=> state_r == dacs_pkg::ST_IDLE && !sda_oe_r)
    else $error("SDA still driven after controller not-acknowledge");
  a_fixed_variant: assert property (HAS_ADDR_PIN == 0 |-> own_addr_r == dacs_pkg::ADDR_FIXED)
    else $error("fixed variant address moved");
endmodule

// >>> testbench/dacs_ctrl_model.sv
// Behavioural I2C bus controller driving the DAC serial target.
// Assumes the bench resolves SDA from all open-drain parties into sda_in.
module dacs_ctrl_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int half = 10;  // SCL phase in clocks; raised to act as a slow controller

  // Bus idles released, SCL high
  initial begin
    scl_out     = 1'h1;
    sda_low_out = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic start_cond();
    sda_low_out <= 1'h0;
    tick(half);
    scl_out <= 1'h1;
    tick(half);
    sda_low_out <= 1'h1;
    tick(half);
    scl_out <= 1'h0;
    tick(2);
  endtask

  task automatic stop_cond();
    sda_low_out <= 1'h1;
    tick(half);
    scl_out <= 1'h1;
    tick(half);
    sda_low_out <= 1'h0;
    tick(half);
  endtask

  // controller owns SCL; data moves only while SCL is low
  task automatic put_bit(input logic b);
    sda_low_out <= ~b;
    tick(half);
    scl_out <= 1'h1;
    tick(half);
    scl_out <= 1'h0;
    tick(2);
  endtask

  // Sample mid-high, well clear of the target's output delay
  task automatic get_bit(output logic b);
    sda_low_out <= 1'h0;
    tick(half);
    scl_out <= 1'h1;
    tick(half / 2);
    b = sda_in;
    tick(half - half / 2);
    scl_out <= 1'h0;
    tick(2);
  endtask

  // byte out, MSB first, ninth slot is the target's answer
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask

  // last byte ends with SDA left high
  task automatic recv_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(last);
  endtask

  // pointer then data, high byte first
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input int n,
                           input logic [15:0] d, output logic ok);
    logic k;
    start_cond();
    send_byte({a, 1'h0}, ok);
    send_byte(p, k);
    ok &= k;
    for (int i = n - 1; i >= 0; i--) begin
      send_byte(d[8*i +: 8], k);
      ok &= k;
    end
    stop_cond();
  endtask

  // pointer write, repeated start, read address, data back
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, input int n,
                          output logic [15:0] d, output logic ok);
    logic k;
    d = 16'h0000;
    start_cond();
    send_byte({a, 1'h0}, ok);
    send_byte(p, k);
    ok &= k;
    start_cond();
    send_byte({a, 1'h1}, k);
    ok &= k;
    for (int i = n - 1; i >= 0; i--) begin
      recv_byte(i == 0, d[8*i +: 8]);
    end
    stop_cond();
  endtask
endmodule

// >>> testbench/dac_i2c_register_slave_tb_top.sv
// Self-checking bench: one strapped and one fixed-address target on one bus.
// Assumes the controller model drives SCL; SDA is a pulled-up open-drain wire.
module dac_i2c_register_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst_n = 1'h0;
  logic [1:0]  strap = 2'h0;
  logic        scl;
  logic        sda_low;
  wire logic   sda;
  logic        so_a;
  logic        oe_a;
  logic        so_b;
  logic        oe_b;
  logic [15:0] code_a;
  logic [15:0] code_b;
  logic [1:0]  pd_a;
  logic [1:0]  pd_b;
  logic [6:0]  adr = dacs_pkg::ADDR_GND;
  logic [15:0] d;
  logic [7:0]  b;
  logic        ok;
  int          n_errors = 0;
  int          checks_done = 0;

  // Any party pulling low wins over the pull-up
  assign sda = ~(sda_low | (oe_a & ~so_a) | (oe_b & ~so_b));

  dacs_ctrl_model u_ctrl (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  dacs_top #(.HAS_ADDR_PIN(1)) u_dut (
    .CLOCK_IN(clk), .RESETN_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda), .ADDR_STRAP_IN(strap),
    .SDA_OUT(so_a), .SDA_OE_OUT(oe_a), .DAC_CODE_OUT(code_a), .POWER_DOWN_SELECT_OUT(pd_a)
  );

  // Fixed-address variant; its strap input is unused
  dacs_top #(.HAS_ADDR_PIN(0)) u_dut_fixed (
    .CLOCK_IN(clk), .RESETN_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda), .ADDR_STRAP_IN(2'h0),
    .SDA_OUT(so_b), .SDA_OE_OUT(oe_b), .DAC_CODE_OUT(code_b), .POWER_DOWN_SELECT_OUT(pd_b)
  );

  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Strap must be steady through capture, so it changes only in reset
  task automatic do_reset(input logic [1:0] s);
    @(posedge clk);
    rst_n <= 1'h0;
    strap <= s;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (8) @(posedge clk);
  endtask

  task automatic t_reset();
    check(code_a, 16'h0000);
    check({14'h0000, pd_a}, 16'h0000);
    check({15'h0000, so_a}, 16'h0000);
    u_ctrl.read_reg(adr, 8'h00, 1, d, ok);
    check(d, 16'h0000);
    u_ctrl.read_reg(adr, 8'h01, 2, d, ok);
    check(d, 16'h0000);
    check({15'h0000, ok}, 16'h0001);
    $display("test reset values done");
  endtask

  // Half-written code must not reach the converter
  task automatic t_word();
    u_ctrl.start_cond();
    u_ctrl.send_byte({adr, 1'h0}, ok);
    u_ctrl.send_byte(8'h01, ok);
    u_ctrl.send_byte(8'hAB, ok);
    check(code_a, 16'h0000);
    u_ctrl.send_byte(8'hCD, ok);
    check(code_a, 16'hABCD);
    u_ctrl.stop_cond();
    u_ctrl.read_reg(adr, 8'h01, 2, d, ok);
    check(d, 16'hABCD);
    u_ctrl.write_reg(adr, 8'h01, 2, 16'hFFFF, ok);
    check(code_a, 16'hFFFF);
    $display("test code word done");
  endtask

  // Upper mode bits are written as ones and must read back zero
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      u_ctrl.write_reg(adr, 8'h00, 1, {8'h00, 6'h3F, 2'(i)}, ok);
      check({14'h0000, pd_a}, 16'(i));
      u_ctrl.read_reg(adr, 8'h00, 1, d, ok);
      check(d, 16'(i));
    end
    check(code_a, 16'hFFFF);
    $display("test modes done");
  endtask

  task automatic t_foreign();
    u_ctrl.write_reg(7'h2C, 8'h01, 2, 16'h1234, ok);
    check({15'h0000, ok}, 16'h0000);
    check(code_a, 16'hFFFF);
    u_ctrl.write_reg(adr, 8'h05, 2, 16'h1234, ok);
    check(code_a, 16'hFFFF);
    check({14'h0000, pd_a}, 16'h0003);
    u_ctrl.read_reg(adr, 8'h05, 2, d, ok);
    check(d, 16'h0000);
    $display("test foreign and unmapped done");
  endtask

  // Slow controller; low byte MSB is zero so a target still driving shows
  task automatic t_nack();
    u_ctrl.half = 30;
    u_ctrl.write_reg(adr, 8'h01, 2, 16'hC03F, ok);
    u_ctrl.start_cond();
    u_ctrl.send_byte({adr, 1'h0}, ok);
    u_ctrl.send_byte(8'h01, ok);
    u_ctrl.start_cond();
    u_ctrl.send_byte({adr, 1'h1}, ok);
    u_ctrl.recv_byte(1'h1, b);
    check({8'h00, b}, 16'h00C0);
    u_ctrl.tick(6);
    check({15'h0000, oe_a}, 16'h0000);
    u_ctrl.stop_cond();
    u_ctrl.half = 10;
    $display("test early end of read done");
  endtask

  task automatic t_straps();
    logic [1:0] st [4] = '{dacs_pkg::STRAP_GND, dacs_pkg::STRAP_VCC, dacs_pkg::STRAP_SDA, dacs_pkg::STRAP_SCL};
    logic [6:0] ad [4] = '{dacs_pkg::ADDR_GND, dacs_pkg::ADDR_VCC, dacs_pkg::ADDR_SDA, dacs_pkg::ADDR_SCL};
    for (int i = 0; i < 4; i++) begin
      do_reset(st[i]);
      check(code_a, 16'h0000);
      u_ctrl.write_reg(ad[i], 8'h01, 2, 16'h0100 + 16'(i), ok);
      check(code_a, 16'h0100 + 16'(i));
      u_ctrl.write_reg(ad[(i + 1) % 4], 8'h01, 2, 16'h7777, ok);
      check(code_a, 16'h0100 + 16'(i));
    end
    $display("test address straps done");
  endtask

  // Strapped target now answers 0001111 only
  task automatic t_fixed();
    u_ctrl.write_reg(dacs_pkg::ADDR_FIXED, 8'h01, 2, 16'h5A5A, ok);
    check(code_b, 16'h5A5A);
    check(code_a, 16'h0103);
    u_ctrl.write_reg(dacs_pkg::ADDR_GND, 8'h01, 2, 16'h1111, ok);
    check({15'h0000, ok}, 16'h0000);
    check(code_b, 16'h5A5A);
    check({14'h0000, pd_b}, 16'h0000);
    $display("test fixed address done");
  endtask

  // Main sequence
  initial begin
    do_reset(dacs_pkg::STRAP_GND);
    t_reset();
    t_word();
    t_modes();
    t_foreign();
    t_nack();
    t_straps();
    t_fixed();
    give_verdict();
  end

  // Watchdog bounds the whole run
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule
